// *** test/testbench.sv ***
// Self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk, rst_n, porRst_n, oscClk, alwaysOnFuse;
    logic       pinResetEvent, brownoutEvent, kickInstruction;
    logic       irqVectorTaken, globalIrqEnable, regWrite, regRead;
    logic [7:0] regAddr, regWdata, regRdata, rd, cause;
    logic       timeoutIrqReq, dogResetPulse, seen;
    int         miscompares, checked, n, cyc;

    watchdog_reset_cause i_dut (
        .clk(clk), .rst_n(rst_n), .porRst_n(porRst_n), .oscClk(oscClk),
        .alwaysOnFuse(alwaysOnFuse), .pinResetEvent(pinResetEvent),
        .brownoutEvent(brownoutEvent), .kickInstruction(kickInstruction),
        .irqVectorTaken(irqVectorTaken), .globalIrqEnable(globalIrqEnable),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata),
        .timeoutIrqReq(timeoutIrqReq), .dogResetPulse(dogResetPulse));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Oscillator at a quarter of the system rate keeps expiries short
    initial begin
        oscClk = 1'b0;
        #7;
        forever #40 oscClk = ~oscClk;
    end

    function automatic logic [7:0] causeAfter(logic [7:0] c, logic [7:0] w);
        return c & {4'h0, w[3:0]};
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(string what, logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic expectReg(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check(what, regRdata, exp);
    endtask
    // Bounded wait on the interrupt request (0) or the reset pulse (1)
    task automatic waitFor(bit which, int limit);
        seen = 1'b0;
        for (cyc = 0; cyc < limit && seen !== 1'b1; cyc++) begin
            @(posedge clk);
            #1 seen = which ? dogResetPulse : timeoutIrqReq;
        end
    endtask
    task automatic disableSeq;
        wr(8'h21, 8'h18);
        wr(8'h21, 8'h00);
        repeat (6) @(posedge clk);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        {rst_n, porRst_n, alwaysOnFuse, pinResetEvent, brownoutEvent} = '0;
        {kickInstruction, irqVectorTaken, globalIrqEnable} = '0;
        {regWrite, regRead, regAddr, regWdata} = '0;
        miscompares = 0;
        checked = 0;
        void'($urandom(90041));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        porRst_n <= 1'b1;
        repeat (4) @(posedge clk);
        expectReg("cause", 8'h34, 8'h01);
        expectReg("ctrl", 8'h21, 8'h00);
        expectReg("unmapped", 8'h22, 8'h00);
        cause = 8'h01;
        for (int i = 0; i < 6; i++) begin
            pinResetEvent <= i[0];
            brownoutEvent <= 1'b1;
            repeat (6) @(posedge clk);
            pinResetEvent <= 1'b0;
            brownoutEvent <= 1'b0;
            repeat (6) @(posedge clk);
            cause = cause | {5'h0, 1'b1, i[0], 1'b0};
            expectReg("cause set", 8'h34, cause);
            n = $urandom;
            wr(8'h34, n[7:0]);
            cause = causeAfter(cause, n[7:0]);
            expectReg("cause write", 8'h34, cause);
        end
        wr(8'h34, 8'h00);
        $display("test cause flags done");
        wr(8'h21, 8'h08);
        expectReg("enable", 8'h21, 8'h08);
        wr(8'h21, 8'h00);
        expectReg("locked", 8'h21, 8'h08);
        wr(8'h21, 8'h18);
        expectReg("window", 8'h21, 8'h18);
        disableSeq();
        expectReg("disabled", 8'h21, 8'h00);
        $display("test level one done");
        globalIrqEnable <= 1'b1;
        wr(8'h21, 8'h40);
        seen = 1'b0;
        for (int i = 0; i < 10; i++) begin
            n = 1000 + ($urandom % 1000);
            repeat (n) begin
                @(posedge clk);
                seen = seen | timeoutIrqReq;
            end
            kickInstruction <= 1'b1;
            @(posedge clk);
            kickInstruction <= 1'b0;
        end
        check("kicked", {7'h0, seen}, 8'h00);
        waitFor(0, 9000);
        check("irq", {7'h0, seen}, 8'h01);
        check("period", {7'h0, cyc > 8150 && cyc < 8250}, 8'h01);
        expectReg("irq ctrl", 8'h21, 8'hc0);
        globalIrqEnable <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("masked", {7'h0, timeoutIrqReq}, 8'h00);
        globalIrqEnable <= 1'b1;
        irqVectorTaken <= 1'b1;
        @(posedge clk);
        irqVectorTaken <= 1'b0;
        expectReg("vector", 8'h21, 8'h40);
        wr(8'h21, 8'hc8);
        waitFor(0, 9000);
        check("combo irq", {7'h0, seen}, 8'h01);
        expectReg("both", 8'h21, 8'h88);
        wr(8'h21, 8'h88);
        expectReg("flag w1", 8'h21, 8'h08);
        waitFor(1, 9000);
        check("reset", {7'h0, seen}, 8'h01);
        @(posedge clk);
        #1 check("pulse", {7'h0, dogResetPulse}, 8'h00);
        expectReg("dog cause", 8'h34, 8'h08);
        disableSeq();
        expectReg("forced", 8'h21, 8'h08);
        wr(8'h34, 8'h00);
        disableSeq();
        expectReg("off", 8'h21, 8'h00);
        $display("test timeout done");
        alwaysOnFuse <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        expectReg("fuse", 8'h21, 8'h08);
        disableSeq();
        expectReg("no disable", 8'h21, 8'h08);
        wr(8'h21, 8'h18);
        wr(8'h21, 8'h03);
        repeat (6) @(posedge clk);
        expectReg("level two", 8'h21, 8'h0b);
        wr(8'h21, 8'h05);
        expectReg("no unlock", 8'h21, 8'h0b);
        expectReg("cause kept", 8'h34, 8'h00);
        $display("test level two done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/watchdog_reset_cause.sv ***
// Watchdog timer with timed unlock and the reset-cause status register
// Operation
// - Counter advances on rising edges of the separate 128 kHz oscillator.
// - The kick instruction clears the counter to zero.
// - Counter also clears when the watchdog is stopped or on chip reset.
// - Ten periods; expiry in reset mode resets the chip.
// - Fuse unprogrammed: starts disabled, enabling and period change free.
// - Fuse programmed: always enabled, enable bit reads one.
// - Level two period change: arm, then period write within four cycles.
// - Level two refuses every disable attempt.
// - Unlock bit clears itself four system clocks after being set.
// - Enable cleared only while unlock bit is one.
// - Enable and irq-enable select stopped, interrupt, reset or both.
// - Expiry with both bits set clears irq-enable in hardware.
// - Expiry in interrupt mode sets flag; vector or write one clears.
// - Interrupt request needs global enable, flag, and irq-enable or a pending combined-mode expiry.
// - Level one: enable forced while the dog reset-cause flag is set.
// - Cause bit 3 set by dog reset; cleared by power-on or zero write.
// - Cause bit 2 set by brown-out; cleared by power-on or zero write.
// - Cause bit 1 set by pin reset; cleared by power-on or zero write.
// - Cause bit 0 set by power-on, cleared by zero write; 7:4 read zero.
// - Control at 0x21: flag 7, irq-en 6, unlock 4, enable 3, period 5,2:0.
// - Period codes zero to nine give 2048 doubling to 1048576 ticks.
// - Reserved period codes fall back to a legal selection.
// - Dog reset is a one system clock pulse.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_cause (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       porRst_n,
    input  wire logic       oscClk,
    input  wire logic       alwaysOnFuse,
    input  wire logic       pinResetEvent,
    input  wire logic       brownoutEvent,
    input  wire logic       kickInstruction,
    input  wire logic       irqVectorTaken,
    input  wire logic       globalIrqEnable,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    output logic            timeoutIrqReq,
    output logic            dogResetPulse
);
    localparam int CW = wdt_pkg::CNT_W;

    // Last counter value for a period code; reserved codes use the longest
    function automatic logic [CW-1:0] lastTick(input logic [3:0] code);
        logic [3:0]  c;
        logic [20:0] span;
        c    = (code > wdt_pkg::PERIOD_MAX) ? wdt_pkg::PERIOD_MAX : code;
        span = (wdt_pkg::BASE_TICKS << c) - 21'h000001;
        return span[CW-1:0];
    endfunction

    logic [2:0]    oscSync_r;
    logic [1:0]    fuseSync_r;
    logic [2:0]    pinSync_r;
    logic [2:0]    brownSync_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic [3:0]    period_r;
    logic [3:0]    period_nxt;
    logic          enable_r;
    logic          enable_nxt;
    logic          irqEn_r;
    logic          irqEn_nxt;
    logic          irqFlag_r;
    logic          irqFlag_nxt;
    logic [2:0]    unlockCnt_r;
    logic [2:0]    unlockCnt_nxt;
    logic [3:0]    cause_r;
    logic [3:0]    cause_nxt;
    logic          comboPend_r;
    logic          comboPend_nxt;
    logic [7:0]    regRdata_r;
    logic          timeoutIrqReq_r;
    logic          dogResetPulse_r;

    wire fuseOn    = fuseSync_r[1];
    wire oscTick   = oscSync_r[1] & ~oscSync_r[2];
    wire pinEdge   = pinSync_r[1] & ~pinSync_r[2];
    wire brownEdge = brownSync_r[1] & ~brownSync_r[2];
    wire unlocked  = (unlockCnt_r != 3'h0);
    wire ctrlWr    = regWrite & (regAddr == wdt_pkg::CTRL_ADDR);
    wire causeWr   = regWrite & (regAddr == wdt_pkg::CAUSE_ADDR);
    wire wrIrqFlag = regWdata[wdt_pkg::CTRL_IRQ_FLAG];
    wire wrIrqEn   = regWdata[wdt_pkg::CTRL_IRQ_EN];
    wire wrUnlock  = regWdata[wdt_pkg::CTRL_UNLOCK];
    wire wrEnable  = regWdata[wdt_pkg::CTRL_ENABLE];
    wire [3:0] wrPeriod = {regWdata[wdt_pkg::CTRL_PER_HI], regWdata[2:0]};
    wire armWrite  = ctrlWr & wrUnlock & wrEnable;
    wire applyWr   = ctrlWr & ~wrUnlock & unlocked;

    // Effective enable: fuse pins it, the dog cause flag holds it at level one
    wire enableEff = fuseOn | enable_r | cause_r[wdt_pkg::CAUSE_DOG];
    wire running   = enableEff | irqEn_r;
    // Compare with >= so that a period shortened under a running count
    // still ends at once instead of wrapping through the whole counter
    wire atLast    = (count_r >= lastTick(period_r));
    wire expired   = oscTick & running & atLast;
    wire resetMode = enableEff & ~irqEn_r;
    wire toIrq     = expired & irqEn_r;
    wire toReset   = expired & ~irqEn_r & enableEff;

    wire [7:0] ctrlView = {irqFlag_r, irqEn_r, period_r[3], unlocked,
                           enableEff, period_r[2:0]};
    wire [7:0] causeView = {4'h0, cause_r};
    wire [7:0] readMux =
        (regAddr == wdt_pkg::CTRL_ADDR)  ? ctrlView  :
        (regAddr == wdt_pkg::CAUSE_ADDR) ? causeView : 8'h00;

    always_comb begin
        count_nxt = count_r;
        if (!running || kickInstruction || expired) begin
            count_nxt = '0;
        end else if (oscTick) begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_comb begin
        unlockCnt_nxt = unlocked ? unlockCnt_r - 3'h1 : 3'h0;
        if (armWrite) begin
            unlockCnt_nxt = wdt_pkg::UNLOCK_CYCLES;
        end
    end

    always_comb begin
        enable_nxt = enable_r;
        period_nxt = period_r;
        if (ctrlWr && wrEnable) begin
            enable_nxt = 1'b1;
        end else if (applyWr && !fuseOn) begin
            enable_nxt = 1'b0;
        end
        if (ctrlWr && !fuseOn) begin
            period_nxt = wrPeriod;
        end else if (applyWr) begin
            period_nxt = wrPeriod;
        end
    end

    always_comb begin
        irqEn_nxt = irqEn_r;
        if (toIrq && enableEff) begin
            irqEn_nxt = 1'b0;
        end
        // A software write in the same cycle wins over the hardware clear
        if (ctrlWr) begin
            irqEn_nxt = wrIrqEn;
        end
        irqFlag_nxt = irqFlag_r;
        if (irqVectorTaken || (ctrlWr && wrIrqFlag)) begin
            irqFlag_nxt = 1'b0;
        end
        if (toIrq) begin
            irqFlag_nxt = 1'b1;
        end
        // Combined mode: the request must outlive the hardware clear of
        // irq-enable, so it is remembered until the flag goes away
        comboPend_nxt = comboPend_r;
        if (!irqFlag_nxt) begin
            comboPend_nxt = 1'b0;
        end
        if (toIrq && enableEff) begin
            comboPend_nxt = 1'b1;
        end
    end

    wire reqNxt = globalIrqEnable & irqFlag_nxt
                  & (irqEn_nxt | comboPend_nxt);

    always_comb begin
        cause_nxt = cause_r;
        if (causeWr) begin
            cause_nxt = cause_r & regWdata[3:0];
        end
        if (dogResetPulse_r) begin
            cause_nxt[wdt_pkg::CAUSE_DOG] = 1'b1;
        end
        if (brownEdge) begin
            cause_nxt[wdt_pkg::CAUSE_BROWN] = 1'b1;
        end
        if (pinEdge) begin
            cause_nxt[wdt_pkg::CAUSE_PIN] = 1'b1;
        end
    end

    // Of the resets only a power-on clears the causes; chip resets must not erase them
    always_ff @(posedge clk or negedge porRst_n) begin
        if (!porRst_n) begin
            cause_r     <= wdt_pkg::CAUSE_POR_VAL;
            pinSync_r   <= 3'h0;
            brownSync_r <= 3'h0;
        end else begin
            cause_r     <= cause_nxt;
            pinSync_r   <= {pinSync_r[1:0], pinResetEvent};
            brownSync_r <= {brownSync_r[1:0], brownoutEvent};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oscSync_r  <= 3'h0;
            fuseSync_r <= 2'h0;
        end else begin
            oscSync_r  <= {oscSync_r[1:0], oscClk};
            fuseSync_r <= {fuseSync_r[0], alwaysOnFuse};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r     <= '0;
            period_r    <= wdt_pkg::PERIOD_RST;
            enable_r    <= 1'b0;
            irqEn_r     <= 1'b0;
            irqFlag_r   <= 1'b0;
            comboPend_r <= 1'b0;
            unlockCnt_r <= 3'h0;
        end else begin
            count_r     <= count_nxt;
            period_r    <= period_nxt;
            enable_r    <= enable_nxt;
            irqEn_r     <= irqEn_nxt;
            irqFlag_r   <= irqFlag_nxt;
            comboPend_r <= comboPend_nxt;
            unlockCnt_r <= unlockCnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r      <= 8'h00;
            timeoutIrqReq_r <= 1'b0;
            dogResetPulse_r <= 1'b0;
        end else begin
            regRdata_r      <= regRead ? readMux : 8'h00;
            timeoutIrqReq_r <= reqNxt;
            dogResetPulse_r <= toReset;
        end
    end

    assign regRdata      = regRdata_r;
    assign timeoutIrqReq = timeoutIrqReq_r;
    assign dogResetPulse = dogResetPulse_r;

    AST_UNLOCK_WINDOW: assert property (@(posedge clk) disable iff (!rst_n)
        armWrite |=> unlocked [*4] ##1 (!unlocked || $past(armWrite)))
        else $error("unlock window not four cycles");
    AST_UNLOCK_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
        unlockCnt_r <= wdt_pkg::UNLOCK_CYCLES)
        else $error("unlock counter out of range");
    AST_FUSE_READS_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == wdt_pkg::CTRL_ADDR && fuseOn && $past(fuseOn))
        |=> regRdata[wdt_pkg::CTRL_ENABLE])
        else $error("enable bit not one under fuse");
    AST_LEVEL2_STAYS_ON: assert property (@(posedge clk) disable iff (!rst_n)
        (fuseOn && $past(fuseOn) && armWrite) ##1 applyWr |=> enableEff)
        else $error("level two watchdog was disabled");
    AST_LOCKED_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWr && !wrEnable && !unlocked && enable_r) |=> enable_r)
        else $error("enable cleared without unlock");
    AST_PULSE_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dogResetPulse_r) |=> !dogResetPulse_r)
        else $error("dog reset pulse longer than a cycle");
    AST_DOG_CAUSE_SET: assert property (@(posedge clk) disable iff (!porRst_n)
        dogResetPulse_r |=> cause_r[wdt_pkg::CAUSE_DOG])
        else $error("dog cause flag not set");
    AST_KICK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        kickInstruction |=> count_r == '0)
        else $error("kick did not clear counter");
    AST_STOPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        !running |=> count_r == '0)
        else $error("stopped counter not zero");
    AST_IE_AUTOCLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (toIrq && enableEff && !ctrlWr) |=> !irqEn_r && irqFlag_r)
        else $error("irq enable not cleared on expiry");
    AST_IRQ_GATING: assert property (@(posedge clk) disable iff (!rst_n)
        timeoutIrqReq_r == $past(reqNxt))
        else $error("interrupt request gating wrong");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
        toIrq |=> irqFlag_r)
        else $error("expiry did not set the irq flag");

    AST_FLAG_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
        (irqVectorTaken && !toIrq) |=> !irqFlag_r)
        else $error("vector did not clear the irq flag");

    AST_FLAG_W1C: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWr && wrIrqFlag && !toIrq) |=> !irqFlag_r)
        else $error("write one did not clear the irq flag");

    AST_COMBO_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        (toIrq && enableEff && globalIrqEnable) |=> timeoutIrqReq_r)
        else $error("combined mode gave no interrupt request");

    AST_RESET_MODE: assert property (@(posedge clk) disable iff (!rst_n)
        dogResetPulse_r |-> $past(resetMode))
        else $error("reset pulse outside reset mode");

    AST_ENABLE_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWr && wrEnable) |=> enable_r)
        else $error("enable write did not enable");

    AST_LEVEL1_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        (!fuseOn && ctrlWr) |=> period_r == $past(wrPeriod))
        else $error("level one period write lost");

    AST_PERIOD_LOCKED: assert property (@(posedge clk) disable iff (!rst_n)
        (fuseOn && ctrlWr && !applyWr) |=> $stable(period_r))
        else $error("level two period changed without unlock");

    AST_PERIOD_APPLY: assert property (@(posedge clk) disable iff (!rst_n)
        (fuseOn && applyWr) |=> period_r == $past(wrPeriod))
        else $error("level two period write in window lost");

    AST_DOG_FORCES_ON: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == wdt_pkg::CTRL_ADDR
         && cause_r[wdt_pkg::CAUSE_DOG]) |=> regRdata[wdt_pkg::CTRL_ENABLE])
        else $error("enable not forced by dog cause flag");

    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr != wdt_pkg::CTRL_ADDR
         && regAddr != wdt_pkg::CAUSE_ADDR) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");

    AST_IDLE_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        !regRead |=> regRdata == 8'h00)
        else $error("read data outside its cycle");

    AST_CAUSE_TOP_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == wdt_pkg::CAUSE_ADDR) |=> regRdata[7:4] == 4'h0)
        else $error("cause upper bits not zero");

    AST_BROWN_SET: assert property (@(posedge clk) disable iff (!porRst_n)
        brownEdge |=> cause_r[wdt_pkg::CAUSE_BROWN])
        else $error("brown-out cause flag not set");

    AST_PIN_SET: assert property (@(posedge clk) disable iff (!porRst_n)
        pinEdge |=> cause_r[wdt_pkg::CAUSE_PIN])
        else $error("pin cause flag not set");

    AST_CAUSE_W1_KEEPS: assert property (@(posedge clk) disable iff (!porRst_n)
        (causeWr && regWdata[wdt_pkg::CAUSE_POWERON]
         && cause_r[wdt_pkg::CAUSE_POWERON]) |=> cause_r[wdt_pkg::CAUSE_POWERON])
        else $error("write one changed a cause flag");

    AST_COUNT_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
        (oscTick && running && !kickInstruction && !expired)
        |=> count_r == $past(count_r) + 1'b1)
        else $error("counter did not advance on a tick");

    COV_RESET_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n)
        dogResetPulse_r);
    COV_IRQ_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n)
        toIrq && enableEff);
    COV_DISABLE_SEQ: cover property (@(posedge clk) disable iff (!rst_n)
        armWrite ##[1:4] (applyWr && !wrEnable));
    COV_PERIOD_LEVEL2: cover property (@(posedge clk) disable iff (!rst_n)
        fuseOn && armWrite ##[1:4] applyWr);

    COV_COMBO_REQ: cover property (@(posedge clk) disable iff (!rst_n)
        comboPend_r && timeoutIrqReq_r);
endmodule
`default_nettype wire

// *** verilog/wdt_pkg.sv ***
// Shared constants for the watchdog and reset-cause block
package wdt_pkg;
    localparam logic [7:0] CTRL_ADDR      = 8'h21;
    localparam logic [7:0] CAUSE_ADDR     = 8'h34;
    localparam int         CTRL_IRQ_FLAG  = 7;
    localparam int         CTRL_IRQ_EN    = 6;
    localparam int         CTRL_PER_HI    = 5;
    localparam int         CTRL_UNLOCK    = 4;
    localparam int         CTRL_ENABLE    = 3;
    localparam int         CAUSE_DOG      = 3;
    localparam int         CAUSE_BROWN    = 2;
    localparam int         CAUSE_PIN      = 1;
    localparam int         CAUSE_POWERON  = 0;
    localparam logic [3:0] CAUSE_POR_VAL  = 4'h1;
    localparam logic [3:0] PERIOD_RST     = 4'h0;
    localparam logic [3:0] PERIOD_MAX     = 4'h9;
    localparam int         OSC_KHZ        = 128;
    localparam int         CNT_W          = 20;
    localparam logic [20:0] BASE_TICKS    = 21'h000800;
    localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
endpackage
